/* common/cspr_pkg.sv */
package cspr_pkg;
  // register offsets
  localparam logic [7:0] REF_LO_ADDR = 8'h00;
  localparam logic [7:0] REF_HI_ADDR = 8'h01;
  localparam logic [7:0] CUR_LIM_ADDR = 8'h02;
  localparam logic [7:0] SLEW_DLY_ADDR = 8'h03;
  localparam logic [7:0] LAST_DEF_ADDR = 8'h07;

  // reset values
  localparam logic [7:0] REF_LO_RST = 8'ha4;
  localparam logic [7:0] REF_HI_RST = 8'h01;
  localparam logic [7:0] CUR_LIM_RST = 8'he4;
  localparam logic [7:0] SLEW_DLY_RST = 8'h01;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // field positions
  localparam int REF_HI_CODE_MSB = 2;
  localparam int CL_EN_BIT = 7;
  localparam int CL_THR_MSB = 6;
  localparam int OCP_DLY_MSB = 5;
  localparam int OCP_DLY_LSB = 4;
  localparam int RAMP_MSB = 1;
  localparam int RAMP_LSB = 0;

  // reference level in tenths of a microvolt
  localparam logic [23:0] REF_BASE_TUV = 24'h06ddd0;
  localparam logic [23:0] REF_STEP_TUV = 24'h00160d;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OCP_T0_NS = 128000;
  localparam int OCP_T1_NS = 3072000;
  localparam int OCP_T2_NS = 6144000;
  localparam int OCP_T3_NS = 12288000;
  localparam int OCP_T0_CYC = OCP_T0_NS / CLK_PERIOD_NS;
  localparam int OCP_T1_CYC = OCP_T1_NS / CLK_PERIOD_NS;
  localparam int OCP_T2_CYC = OCP_T2_NS / CLK_PERIOD_NS;
  localparam int OCP_T3_CYC = OCP_T3_NS / CLK_PERIOD_NS;
  localparam int OCP_CNT_W = 21;
endpackage

/* hdl/cspr_byte_reg.sv */
`timescale 1ns/1ns
module cspr_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [7:0] d,
  output logic [7:0] q_r
);
  logic [7:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt = d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

/* hdl/cspr_regs.sv */
`timescale 1ns/1ns
// Overview of operation
// - reference spans 01h high, 00h low
// - bits 10-0 code, 15-11 reserved rw
// - reference resets to 01a4h, 282 mV
// - level is 45 mV plus 0.5645 mV per code
// - bit 7 enables current limit, resets set
// - bits 6-0 threshold, 0.5 mV steps
// - current limit resets to e4h, 50 mV
// - bits 5-4 select overcurrent response delay
// - bits 1-0 select output ramp rate
// - register 03h reserved bits rw, resets 01h
// - addresses above 07h answered with nack
module cspr_regs
  import cspr_pkg::*;
#(
  parameter int DLY0_CYC = cspr_pkg::OCP_T0_CYC,
  parameter int DLY1_CYC = cspr_pkg::OCP_T1_CYC,
  parameter int DLY2_CYC = cspr_pkg::OCP_T2_CYC,
  parameter int DLY3_CYC = cspr_pkg::OCP_T3_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  output logic reg_ack_r,
  output logic reg_nack_r,
  output logic [10:0] ref_code_r,
  output logic [23:0] ref_level_r,
  output logic cl_enable_r,
  output logic [6:0] cl_threshold_r,
  output logic [1:0] overcurrent_response_delay_r,
  output logic [1:0] output_ramp_rate_r,
  input wire logic limit_hit,
  output logic ocp_trip_r
);
  import cspr_pkg::*;

  localparam int CNT_MAX = (1 << OCP_CNT_W) - 1;

  if (DLY0_CYC < 1 || DLY1_CYC < 1 || DLY2_CYC < 1 || DLY3_CYC < 1) begin : g_bad_min
    $error("overcurrent delay counts must be at least one cycle");
  end
  if (DLY0_CYC > CNT_MAX || DLY1_CYC > CNT_MAX || DLY2_CYC > CNT_MAX || DLY3_CYC > CNT_MAX) begin : g_bad_max
    $error("overcurrent delay counts exceed the counter width");
  end

  // ---------------------------------------------------------------- decode
  logic access;
  logic addr_ok;
  logic we_lo;
  logic we_hi;
  logic we_cl;
  logic we_sd;

  always_comb begin
    access = reg_wr || reg_rd;
    addr_ok = (reg_addr <= LAST_DEF_ADDR);
    we_lo = 1'b0;
    we_hi = 1'b0;
    we_cl = 1'b0;
    we_sd = 1'b0;
    if (!reg_wr) begin
      we_lo = 1'b0;
    end else if (reg_addr == REF_LO_ADDR) begin
      we_lo = 1'b1;
    end else if (reg_addr == REF_HI_ADDR) begin
      we_hi = 1'b1;
    end else if (reg_addr == CUR_LIM_ADDR) begin
      we_cl = 1'b1;
    end else if (reg_addr == SLEW_DLY_ADDR) begin
      we_sd = 1'b1;
    end
  end

  // ---------------------------------------------------------------- storage
  logic [7:0] ref_lo_q;
  logic [7:0] ref_hi_q;
  logic [7:0] cur_lim_q;
  logic [7:0] slew_dly_q;

  // low byte held until the high byte arrives
  cspr_byte_reg #(.RST_VAL(REF_LO_RST)) u_ref_lo (
    .mclk(mclk),
    .nrst(nrst),
    .we(we_lo),
    .d(reg_wdata),
    .q_r(ref_lo_q)
  );

  // reserved upper bits kept as plain storage
  cspr_byte_reg #(.RST_VAL(REF_HI_RST)) u_ref_hi (
    .mclk(mclk),
    .nrst(nrst),
    .we(we_hi),
    .d(reg_wdata),
    .q_r(ref_hi_q)
  );

  cspr_byte_reg #(.RST_VAL(CUR_LIM_RST)) u_cur_lim (
    .mclk(mclk),
    .nrst(nrst),
    .we(we_cl),
    .d(reg_wdata),
    .q_r(cur_lim_q)
  );

  cspr_byte_reg #(.RST_VAL(SLEW_DLY_RST)) u_slew_dly (
    .mclk(mclk),
    .nrst(nrst),
    .we(we_sd),
    .d(reg_wdata),
    .q_r(slew_dly_q)
  );

  // ---------------------------------------------------------------- bus answer and settings
  logic [7:0] rdata_nxt;
  logic ack_nxt;
  logic nack_nxt;
  logic [10:0] ref_code_nxt;
  logic [23:0] ref_level_nxt;
  logic cl_enable_nxt;
  logic [6:0] cl_threshold_nxt;
  logic [1:0] ocp_dly_nxt;
  logic [1:0] ramp_nxt;

  always_comb begin
    rdata_nxt = reg_rdata_r;
    ack_nxt = access && addr_ok;
    nack_nxt = access && !addr_ok;
    if (!(reg_rd && addr_ok)) begin
      rdata_nxt = reg_rdata_r;
    end else if (reg_addr == REF_LO_ADDR) begin
      rdata_nxt = ref_lo_q;
    end else if (reg_addr == REF_HI_ADDR) begin
      rdata_nxt = ref_hi_q;
    end else if (reg_addr == CUR_LIM_ADDR) begin
      rdata_nxt = cur_lim_q;
    end else if (reg_addr == SLEW_DLY_ADDR) begin
      rdata_nxt = slew_dly_q;
    end else begin
      rdata_nxt = READ_ZERO;
    end

    ref_code_nxt = ref_code_r;
    if (we_hi) begin
      ref_code_nxt = {reg_wdata[REF_HI_CODE_MSB:0], ref_lo_q};
    end
    ref_level_nxt = REF_BASE_TUV + 24'(ref_code_r) * REF_STEP_TUV;
    cl_enable_nxt = cur_lim_q[CL_EN_BIT];
    cl_threshold_nxt = cur_lim_q[CL_THR_MSB:0];
    ocp_dly_nxt = slew_dly_q[OCP_DLY_MSB:OCP_DLY_LSB];
    ramp_nxt = slew_dly_q[RAMP_MSB:RAMP_LSB];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= READ_ZERO;
      reg_ack_r <= 1'b0;
      reg_nack_r <= 1'b0;
      ref_code_r <= {REF_HI_RST[REF_HI_CODE_MSB:0], REF_LO_RST};
      ref_level_r <= REF_BASE_TUV + 24'({REF_HI_RST[REF_HI_CODE_MSB:0], REF_LO_RST}) * REF_STEP_TUV;
      cl_enable_r <= CUR_LIM_RST[CL_EN_BIT];
      cl_threshold_r <= CUR_LIM_RST[CL_THR_MSB:0];
      overcurrent_response_delay_r <= SLEW_DLY_RST[OCP_DLY_MSB:OCP_DLY_LSB];
      output_ramp_rate_r <= SLEW_DLY_RST[RAMP_MSB:RAMP_LSB];
    end else begin
      reg_rdata_r <= rdata_nxt;
      reg_ack_r <= ack_nxt;
      reg_nack_r <= nack_nxt;
      ref_code_r <= ref_code_nxt;
      ref_level_r <= ref_level_nxt;
      cl_enable_r <= cl_enable_nxt;
      cl_threshold_r <= cl_threshold_nxt;
      overcurrent_response_delay_r <= ocp_dly_nxt;
      output_ramp_rate_r <= ramp_nxt;
    end
  end

  // ---------------------------------------------------------------- overcurrent delay timer
  // comparator output is asynchronous to mclk
  logic lim_s1_r;
  logic lim_s2_r;
  logic [OCP_CNT_W-1:0] ocp_cnt_r;
  logic [OCP_CNT_W-1:0] ocp_cnt_nxt;
  logic [OCP_CNT_W-1:0] dly_last;
  logic ocp_trip_nxt;

  always_comb begin
    case (overcurrent_response_delay_r)
      2'h0: dly_last = OCP_CNT_W'(DLY0_CYC - 1);
      2'h1: dly_last = OCP_CNT_W'(DLY1_CYC - 1);
      2'h2: dly_last = OCP_CNT_W'(DLY2_CYC - 1);
      default: dly_last = OCP_CNT_W'(DLY3_CYC - 1);
    endcase
    ocp_cnt_nxt = ocp_cnt_r;
    ocp_trip_nxt = ocp_trip_r;
    if (!(cl_enable_r && lim_s2_r)) begin
      ocp_cnt_nxt = '0;
      ocp_trip_nxt = 1'b0;
    end else if (ocp_cnt_r >= dly_last) begin
      ocp_trip_nxt = 1'b1;
    end else begin
      ocp_cnt_nxt = ocp_cnt_r + OCP_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lim_s1_r <= 1'b0;
      lim_s2_r <= 1'b0;
      ocp_cnt_r <= '0;
      ocp_trip_r <= 1'b0;
    end else begin
      lim_s1_r <= limit_hit;
      lim_s2_r <= lim_s1_r;
      ocp_cnt_r <= ocp_cnt_nxt;
      ocp_trip_r <= ocp_trip_nxt;
    end
  end

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence wr_to(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  sequence rd_back(logic [7:0] a);
    reg_rd && reg_addr == a && !reg_wr;
  endsequence

  reset_values_a: assert property ($rose(nrst) |-> ref_code_r == 11'h1a4 && cl_enable_r
    && cl_threshold_r == 7'h64 && overcurrent_response_delay_r == 2'h0 && output_ramp_rate_r == 2'h1)
    else $error("settings differ from reset values");

  low_byte_held_a: assert property (wr_to(REF_LO_ADDR) |=> $stable(ref_code_r))
    else $error("low byte write changed active reference");

  high_byte_apply_a: assert property (wr_to(REF_HI_ADDR)
    |=> ref_code_r == {$past(reg_wdata[2:0]), $past(ref_lo_q)})
    else $error("high byte write did not apply combined code");

  ref_reserved_rw_a: assert property (wr_to(REF_HI_ADDR) ##1 rd_back(REF_HI_ADDR)
    |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("reserved reference bits not read back");

  ref_level_map_a: assert property (##1 1'b1 |->
    ref_level_r == 24'h06ddd0 + 24'($past(ref_code_r)) * 24'h00160d)
    else $error("reference level mapping wrong");

  limit_enable_a: assert property (wr_to(CUR_LIM_ADDR) |=> ##1 cl_enable_r == $past(reg_wdata[7], 2))
    else $error("limit enable does not follow bit 7");

  limit_thresh_a: assert property (wr_to(CUR_LIM_ADDR) |=> ##1 cl_threshold_r == $past(reg_wdata[6:0], 2))
    else $error("limit threshold does not follow bits 6-0");

  limit_rst_val_a: assert property ($rose(nrst) |-> cur_lim_q == 8'he4)
    else $error("current limit register reset value wrong");

  delay_trip_a: assert property ($rose(ocp_trip_r) |-> $past(ocp_cnt_r) == dly_last
    && $past(lim_s2_r) && $past(cl_enable_r))
    else $error("overcurrent trip at wrong count");

  ramp_follow_a: assert property (wr_to(SLEW_DLY_ADDR) |=> ##1 output_ramp_rate_r == $past(reg_wdata[1:0], 2))
    else $error("ramp rate does not follow bits 1-0");

  slew_rw_a: assert property (wr_to(SLEW_DLY_ADDR) ##1 rd_back(SLEW_DLY_ADDR)
    |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("slew delay register not read back whole");

  bad_addr_nack_a: assert property ((reg_wr || reg_rd) && reg_addr > 8'h07
    |=> reg_nack_r && !reg_ack_r)
    else $error("undefined address not refused");
endmodule

/* verif/cspr_ctrl_model.sv */
`timescale 1ns/1ns
module cspr_ctrl_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  input wire logic reg_ack_r,
  input wire logic reg_nack_r
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // one strobe pulse; answer sampled 1 ns after the taking edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q, output logic ak, output logic nk);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines show inverted data, not the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata_r;
    ak = reg_ack_r;
    nk = reg_nack_r;
  endtask

  // write then read of one register on consecutive taking edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic ak);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~d;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    q = reg_rdata_r;
    ak = reg_ack_r;
  endtask

  // low byte first, then high byte
  task automatic set_ref(input logic [15:0] v);
    logic [7:0] q;
    logic ak;
    logic nk;
    xfer(8'h00, 1'b1, v[7:0], q, ak, nk);
    xfer(8'h01, 1'b1, v[15:8], q, ak, nk);
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import cspr_pkg::*;
  logic mclk;
  logic nrst;
  logic limit_hit;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_r;
  logic reg_wr;
  logic reg_rd;
  logic reg_ack_r;
  logic reg_nack_r;
  logic cl_enable_r;
  logic ocp_trip_r;
  logic [10:0] ref_code_r;
  logic [23:0] ref_level_r;
  logic [6:0] cl_threshold_r;
  logic [1:0] overcurrent_response_delay_r;
  logic [1:0] output_ramp_rate_r;
  logic [7:0] q;
  logic ak;
  logic nk;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  cspr_regs #(.DLY0_CYC(4), .DLY1_CYC(8), .DLY2_CYC(12), .DLY3_CYC(16)) u_dut (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
    .reg_nack_r(reg_nack_r), .ref_code_r(ref_code_r), .ref_level_r(ref_level_r),
    .cl_enable_r(cl_enable_r), .cl_threshold_r(cl_threshold_r),
    .overcurrent_response_delay_r(overcurrent_response_delay_r),
    .output_ramp_rate_r(output_ramp_rate_r), .limit_hit(limit_hit), .ocp_trip_r(ocp_trip_r));

  cspr_ctrl_model u_ctrl (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r), .reg_nack_r(reg_nack_r));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_ctrl.xfer(a, 1'b0, 8'h00, q, ak, nk);
    cmp("reg_ack_r", 24'h1, {23'h0, ak});
    cmp("reg_rdata_r", {16'h0, e}, {16'h0, q});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ctrl.xfer(a, 1'b1, d, q, ak, nk);
    cmp("reg_ack_r", 24'h1, {23'h0, ak});
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic out_chk(input logic [10:0] c, input logic [23:0] l, input logic en,
                         input logic [6:0] t, input logic [1:0] dl, input logic [1:0] rr);
    cmp("ref_code_r", {13'h0, c}, {13'h0, ref_code_r});
    cmp("ref_level_r", l, ref_level_r);
    cmp("cl_enable_r", {23'h0, en}, {23'h0, cl_enable_r});
    cmp("cl_threshold_r", {17'h0, t}, {17'h0, cl_threshold_r});
    cmp("delay_code", {22'h0, dl}, {22'h0, overcurrent_response_delay_r});
    cmp("ramp_code", {22'h0, rr}, {22'h0, output_ramp_rate_r});
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    nrst = 1'b0;
    limit_hit = 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    out_chk(11'h1a4, 24'd2820900, 1'b1, 7'h64, 2'h0, 2'h1);
    rd_chk(8'h00, 8'ha4);
    rd_chk(8'h01, 8'h01);
    rd_chk(8'h02, 8'he4);
    rd_chk(8'h03, 8'h01);
    wr(8'h00, 8'hfe);
    cmp("ref_code_r", 24'h1a4, {13'h0, ref_code_r});
    rd_chk(8'h00, 8'hfe);
    wr(8'h01, 8'hff);
    out_chk(11'h7fe, 24'd11999670, 1'b1, 7'h64, 2'h0, 2'h1);
    rd_chk(8'h01, 8'hff);
    u_ctrl.wr_rd(8'h01, 8'hf9, q, ak);
    cmp("reg_ack_r", 24'h1, {23'h0, ak});
    cmp("reg_rdata_r", 24'hf9, {16'h0, q});
    u_ctrl.set_ref(16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    u_ctrl.wr_rd(8'h03, 8'hcc, q, ak);
    cmp("reg_ack_r", 24'h1, {23'h0, ak});
    cmp("reg_rdata_r", 24'hcc, {16'h0, q});
    wr(8'h02, 8'h7f);
    wr(8'h03, 8'hff);
    out_chk(11'h000, 24'd450000, 1'b0, 7'h7f, 2'h3, 2'h3);
    rd_chk(8'h03, 8'hff);
    u_ctrl.xfer(8'h08, 1'b1, 8'h00, q, ak, nk);
    cmp("reg_nack_r", 24'h1, {23'h0, nk});
    cmp("reg_ack_r", 24'h0, {23'h0, ak});
    cmp("reg_rdata_r", 24'hff, {16'h0, q});
    wr(8'h02, 8'he4);
    for (int k = 0; k < 4; k++) begin
      wr(8'h03, {2'b00, k[1:0], 4'h1});
      @(posedge mclk);
      limit_hit <= 1'b1;
      repeat (4 * (k + 1) + 1) @(posedge mclk);
      #1;
      cmp("ocp_trip_r", 24'h0, {23'h0, ocp_trip_r});
      @(posedge mclk);
      #1;
      cmp("ocp_trip_r", 24'h1, {23'h0, ocp_trip_r});
      @(posedge mclk);
      limit_hit <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      cmp("ocp_trip_r", 24'h0, {23'h0, ocp_trip_r});
    end
    wr(8'h02, 8'h64);
    @(posedge mclk);
    limit_hit <= 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    cmp("ocp_trip_r", 24'h0, {23'h0, ocp_trip_r});
    stop_test();
  end
endmodule
